// [common/instr_exec_pkg.sv]
/*
  Constants, opcode fields and carrier types for the execute unit of the
  increment, OR, move and jump instruction group.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
package instr_exec_pkg;
  localparam int INSTR_W = 14;
  localparam int FADDR_W = 7;
  localparam int DATA_W  = 8;
  localparam int PC_W    = 13;
  localparam int JUMP_W  = 11;

  // opcode field of file and literal ops, instruction bits 13:8
  localparam logic [5:0] OP_INC_SKIP = 6'h0F;
  localparam logic [5:0] OP_INC      = 6'h0A;
  localparam logic [5:0] OP_OR_FILE  = 6'h04;
  localparam logic [5:0] OP_COPY     = 6'h08;
  localparam logic [5:0] OP_OR_LIT   = 6'h38;
  // jump opcode, instruction bits 13:11
  localparam logic [2:0] OP_JUMP     = 3'h5;

  localparam int DEST_BIT = 7;
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;

  localparam logic [7:0]  W_RST    = 8'h00;
  localparam logic        Z_RST    = 1'b0;
  localparam logic [12:0] PC_RST   = 13'h0000;
  localparam logic [6:0]  ADDR_RST = 7'h00;
  localparam logic [7:0]  ONE      = 8'h01;
  localparam logic [7:0]  ZERO     = 8'h00;

  typedef enum logic [1:0] {
    ST_EXEC   = 2'b01,
    ST_SQUASH = 2'b10
  } exec_state_t;

  typedef struct packed {
    logic        incSkip;
    logic        inc;
    logic        orFile;
    logic        copy;
    logic        jump;
    logic        orLit;
    logic        dest;
    logic [6:0]  addr;
    logic [7:0]  lit;
    logic [10:0] target;
  } decode_t;
endpackage : instr_exec_pkg

// [logic/instr_exec.sv]
/*
  Execute unit for increment (with and without skip), OR with literal,
  OR with file, file move and unconditional jump.
  Assumes the fetch stage presents one instruction per cycle with
  instrValid, the addressed file register value combinationally on
  fileData in the same cycle, and the program counter high latch on
  pcHighLatch. All inputs come from logic on clk.
*/
// Function
// - zero sum makes next instruction a no-op, two cycles total
// - destination bit 0 writes working reg, 1 writes file register
// - jump loads 11-bit immediate into program counter bits 10:0
// - jump loads pc bits 12:11 from latch bits 4:3, flags unchanged
// - jump takes two cycles, the fetched next instruction discarded
// - OR literal into working reg and update zero flag
// - plain increment writes destination, updates zero flag, never skips
// - OR working reg with file register to destination, update zero
// - copy file value to destination, zero flag updated either way
module instr_exec (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        instrValid,
  input  wire logic [13:0] instr,
  input  wire logic [7:0]  fileData,
  input  wire logic [7:0]  pcHighLatch,
  output logic      [7:0]  wReg,
  output logic             zeroFlag,
  output logic             fileWe,
  output logic      [6:0]  fileAddr,
  output logic      [7:0]  fileWdata,
  output logic             pcLoad,
  output logic      [12:0] pcTarget,
  output logic             squashed
);

  function automatic logic isZero(input logic [7:0] v);
    return v == instr_exec_pkg::ZERO;
  endfunction : isZero

  instr_exec_pkg::exec_state_t state_reg;
  instr_exec_pkg::exec_state_t state_next;
  instr_exec_pkg::decode_t     dec;

  logic       execNow;
  logic       fileOp;
  logic [7:0] sum;
  logic       sumZero;
  logic [7:0] result;
  logic       writesZ;
  logic       toFile;
  logic       toW;
  logic       takeSkip;

  // decode
  assign dec.incSkip = instr[13:8] == instr_exec_pkg::OP_INC_SKIP;
  assign dec.inc     = instr[13:8] == instr_exec_pkg::OP_INC;
  assign dec.orFile  = instr[13:8] == instr_exec_pkg::OP_OR_FILE;
  assign dec.copy    = instr[13:8] == instr_exec_pkg::OP_COPY;
  assign dec.orLit   = instr[13:8] == instr_exec_pkg::OP_OR_LIT;
  assign dec.jump    = instr[13:11] == instr_exec_pkg::OP_JUMP;
  assign dec.dest    = instr[instr_exec_pkg::DEST_BIT];
  assign dec.addr    = instr[6:0];
  assign dec.lit     = instr[7:0];
  assign dec.target  = instr[10:0];

  assign execNow = instrValid && state_reg == instr_exec_pkg::ST_EXEC;
  assign fileOp  = dec.incSkip | dec.inc | dec.orFile | dec.copy;

  // datapath
  assign sum     = fileData + instr_exec_pkg::ONE;
  assign sumZero = isZero(sum);
  assign result  = (dec.incSkip | dec.inc) ? sum :
                   dec.orFile ? (wReg | fileData) :
                   dec.orLit  ? (wReg | dec.lit) :
                   fileData;
  // increment-skip and jump leave the zero flag alone
  assign writesZ = dec.inc | dec.orFile | dec.copy | dec.orLit;
  assign toFile  = fileOp & dec.dest;
  assign toW     = dec.orLit | (fileOp & ~dec.dest);
  assign takeSkip = dec.incSkip & sumZero;

  // one squash cycle follows a taken skip or a jump
  always_comb begin
    case (state_reg)
      instr_exec_pkg::ST_EXEC: begin
        if (instrValid && (takeSkip || dec.jump)) begin
          state_next = instr_exec_pkg::ST_SQUASH;
        end else begin
          state_next = instr_exec_pkg::ST_EXEC;
        end
      end
      instr_exec_pkg::ST_SQUASH: begin
        state_next = instrValid ? instr_exec_pkg::ST_EXEC
                                : instr_exec_pkg::ST_SQUASH;
      end
      default: state_next = instr_exec_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= instr_exec_pkg::ST_EXEC;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wReg     <= instr_exec_pkg::W_RST;
      zeroFlag <= instr_exec_pkg::Z_RST;
    end else if (execNow) begin
      if (toW) begin
        wReg <= result;
      end
      if (writesZ) begin
        zeroFlag <= isZero(result);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fileWe    <= 1'b0;
      fileAddr  <= instr_exec_pkg::ADDR_RST;
      fileWdata <= instr_exec_pkg::ZERO;
      pcLoad    <= 1'b0;
      pcTarget  <= instr_exec_pkg::PC_RST;
      squashed  <= 1'b0;
    end else begin
      fileWe    <= execNow & toFile;
      fileAddr  <= dec.addr;
      fileWdata <= result;
      pcLoad    <= execNow & dec.jump;
      pcTarget  <= {pcHighLatch[instr_exec_pkg::LATCH_HI:
                                instr_exec_pkg::LATCH_LO],
                    dec.target};
      squashed  <= instrValid &&
                   state_reg == instr_exec_pkg::ST_SQUASH;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_skip_on_zero: assert property (
    execNow && takeSkip ##1 instrValid |=> squashed && !fileWe && !pcLoad)
    else $error("skip did not squash next instruction");

  a_skip_flags: assert property (
    execNow && dec.incSkip |=> $stable(zeroFlag))
    else $error("increment-skip changed zero flag");

  a_no_skip_nz: assert property (
    execNow && dec.incSkip && !sumZero |=> state_reg == instr_exec_pkg::ST_EXEC)
    else $error("nonzero increment-skip skipped");

  a_dest_file: assert property (
    execNow && dec.inc && dec.dest
    |=> fileWe && fileWdata == 8'($past(fileData) + 8'h01)
        && state_reg == instr_exec_pkg::ST_EXEC)
    else $error("increment to file wrong");

  a_jump_target: assert property (
    execNow && dec.jump
    |=> pcLoad && pcTarget[10:0] == $past(instr[10:0]))
    else $error("jump low target wrong");

  a_jump_high: assert property (
    execNow && dec.jump
    |=> pcTarget[12:11] == $past(pcHighLatch[4:3]) && $stable(zeroFlag))
    else $error("jump high bits or flag wrong");

  a_jump_squash: assert property (
    execNow && dec.jump ##1 instrValid[*1] |=> squashed && !fileWe)
    else $error("jump did not discard next instruction");

  a_or_literal: assert property (
    execNow && dec.orLit
    |=> wReg == ($past(wReg) | $past(instr[7:0]))
        && zeroFlag == (wReg == 8'h00))
    else $error("or literal wrong");

  a_or_file: assert property (
    execNow && dec.orFile && !dec.dest
    |=> wReg == ($past(wReg) | $past(fileData)) && !fileWe)
    else $error("or with file to working reg wrong");

  a_copy_zero: assert property (
    execNow && dec.copy
    |=> zeroFlag == ($past(fileData) == 8'h00))
    else $error("copy did not update zero flag");

  a_zero_flag: assert property (
    execNow && writesZ |=> zeroFlag == ($past(result) == 8'h00))
    else $error("zero flag mismatch");

  a_single_cycle: assert property (
    execNow && !dec.jump && !takeSkip
    |=> state_reg == instr_exec_pkg::ST_EXEC && !squashed)
    else $error("single-cycle instruction stalled");

  c_skip_taken: cover property (execNow && takeSkip ##1 instrValid);
  c_jump:       cover property (execNow && dec.jump ##1 instrValid);
  c_copy_file:  cover property (execNow && dec.copy && dec.dest);
  c_or_zero:    cover property (execNow && dec.orLit && isZero(result));

endmodule : instr_exec

// [logic/instr_exec_unused_guard.sv]
/*
  Holds no logic: the whole execute unit lives in instr_exec.sv.
*/

// [tb/tb.sv]
/*
  Self-checking bench for the instr_exec execute unit.
  Assumes the design answers one edge after taking an instruction.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        sysRst;
  logic        instrValid;
  logic [13:0] instr;
  logic [7:0]  fileData;
  logic [7:0]  pcHighLatch;
  logic [7:0]  wReg;
  logic        zeroFlag;
  logic        fileWe;
  logic [6:0]  fileAddr;
  logic [7:0]  fileWdata;
  logic        pcLoad;
  logic [12:0] pcTarget;
  logic        squashed;
  int          nFail;
  int          nTests;
  int          cycles;

  instr_exec u_instr_exec (.clk(clk), .sys_rst(sysRst),
    .instrValid(instrValid), .instr(instr), .fileData(fileData),
    .pcHighLatch(pcHighLatch), .wReg(wReg), .zeroFlag(zeroFlag),
    .fileWe(fileWe), .fileAddr(fileAddr), .fileWdata(fileWdata),
    .pcLoad(pcLoad), .pcTarget(pcTarget), .squashed(squashed));

  always #4 clk = ~clk;

  task close_out;
    $display("tests %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      nFail++;
      close_out;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // file op word: opcode, destination, address
  function automatic logic [13:0] fop(logic [5:0] op, logic d);
    return {op, d, 7'h12};
  endfunction : fop

  task exec(input logic [13:0] i, input logic [7:0] fd);
    instr = i;
    fileData = fd;
    instrValid = 1'b1;
    @(posedge clk);
    @(negedge clk);
  endtask : exec

  task idle(input string name);
    instrValid = 1'b0;
    @(negedge clk);
    $display("test %s done", name);
  endtask : idle

  task t_or_lit;
    exec({instr_exec_pkg::OP_OR_LIT, 8'h00}, 8'h00);
    chk(zeroFlag, 1'b1);
    exec({instr_exec_pkg::OP_OR_LIT, 8'hA5}, 8'h00);
    chk(wReg, 8'hA5);
    chk(zeroFlag, 1'b0);
    idle("or_lit");
  endtask : t_or_lit

  task t_inc;
    exec(fop(instr_exec_pkg::OP_INC, 1'b1), 8'hFF);
    chk({fileWe, fileAddr}, 8'h92);
    chk(fileWdata, 8'h00);
    chk(zeroFlag, 1'b1);
    chk(wReg, 8'hA5);
    exec(fop(instr_exec_pkg::OP_INC, 1'b0), 8'h3C);
    chk({fileWe, squashed, wReg}, 10'h03D);
    chk(zeroFlag, 1'b0);
    exec(fop(instr_exec_pkg::OP_OR_FILE, 1'b1), 8'hC0);
    chk({fileWe, fileWdata, wReg}, 17'h1FD3D);
    exec(fop(instr_exec_pkg::OP_COPY, 1'b1), 8'h00);
    chk({fileWe, fileWdata, zeroFlag}, 10'h201);
    exec(fop(instr_exec_pkg::OP_COPY, 1'b0), 8'h80);
    chk({fileWe, wReg, zeroFlag}, 10'h100);
    exec(fop(instr_exec_pkg::OP_OR_FILE, 1'b0), 8'h05);
    chk({fileWe, wReg, zeroFlag}, 10'h10A);
    idle("file_ops");
  endtask : t_inc

  task t_skip;
    exec(fop(instr_exec_pkg::OP_INC_SKIP, 1'b0), 8'hFF);
    chk({wReg, zeroFlag}, 9'h000);
    exec({instr_exec_pkg::OP_OR_LIT, 8'h0F}, 8'h00);
    chk({squashed, wReg}, 9'h100);
    exec(fop(instr_exec_pkg::OP_INC_SKIP, 1'b1), 8'h41);
    chk({fileWe, fileWdata, zeroFlag}, 10'h284);
    exec({instr_exec_pkg::OP_OR_LIT, 8'h01}, 8'h00);
    chk({squashed, wReg}, 9'h001);
    idle("skip");
  endtask : t_skip

  task t_jump;
    pcHighLatch = 8'h18;
    exec({instr_exec_pkg::OP_JUMP, 11'h7FF}, 8'h00);
    chk({pcLoad, pcTarget}, 14'h3FFF);
    chk(zeroFlag, 1'b0);
    exec(fop(instr_exec_pkg::OP_INC, 1'b1), 8'hFF);
    chk({squashed, fileWe, pcLoad, zeroFlag}, 4'h8);
    pcHighLatch = 8'hE7;
    exec({instr_exec_pkg::OP_JUMP, 11'h2AA}, 8'h00);
    chk({pcLoad, pcTarget}, 14'h22AA);
    // an idle cycle must not use up the pending discard
    instrValid = 1'b0;
    @(negedge clk);
    chk(squashed, 1'b0);
    exec({instr_exec_pkg::OP_OR_LIT, 8'hFF}, 8'h00);
    chk({squashed, wReg, zeroFlag}, 10'h202);
    idle("jump");
  endtask : t_jump

  // reset in mid-run drops a pending discard
  task t_reset;
    exec({instr_exec_pkg::OP_JUMP, 11'h155}, 8'h00);
    sysRst = 1'b1;
    instrValid = 1'b0;
    repeat (2) @(negedge clk);
    sysRst = 1'b0;
    chk({wReg, zeroFlag, pcLoad, pcTarget}, 23'h000000);
    exec({instr_exec_pkg::OP_OR_LIT, 8'h3C}, 8'h00);
    chk({squashed, wReg}, 9'h03C);
    idle("reset");
  endtask : t_reset

  initial begin
    clk = 1'b0;
    sysRst = 1'b1;
    instrValid = 1'b0;
    instr = 14'h0000;
    fileData = 8'h00;
    pcHighLatch = 8'h00;
    nFail = 0;
    nTests = 0;
    cycles = 0;
    repeat (20) @(negedge clk);
    sysRst = 1'b0;
    chk({wReg, zeroFlag, fileWe, pcLoad, squashed}, 12'h000);
    t_or_lit;
    t_inc;
    t_skip;
    t_jump;
    t_reset;
    close_out;
  end
endmodule : tb
